// ===== shared/pwr_cmd_map.vh
// constants for the power switch command sender
// ********************************************************************
// ********************************************************************
`ifndef PWR_CMD_MAP_VH
`define PWR_CMD_MAP_VH
`define CH_P 8'h50
`define CH_EQ 8'h3D
`define CH_ZERO 8'h30
`define CH_ONE 8'h31
`define CH_CR 8'h0D
`define CH_BSL 8'h5C
`define CH_STAR 8'h2A
`define MAX_OUT 3'h4
`define NUM_HOSTS 4'h8
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define DEF_BAUD_DIV 16'h0364
// character slots of one command, token first so a chain starts at 0
`define CI_BSL 3'h0
`define CI_STAR 3'h1
`define CI_P 3'h2
`define CI_BOX 3'h3
`define CI_PORT 3'h4
`define CI_EQ 3'h5
`define CI_ST 3'h6
`define CI_CR 3'h7
// largest digit a single ascii character can carry
`define MAX_DIGIT 4'h9
// entries in the outlet table, hosts times slots
`define TBL_SIZE 32
// start, eight data and stop bit of one serial frame
`define FRAME_BITS 4'hA
`define LINE_IDLE 10'h3FF
`endif

// ===== src/pwr_cmd_fifo.v
// byte fifo between the command framer and the uart transmitter
`timescale 1ns/1ns
module pwr_cmd_fifo #(
   parameter W = 8,
   parameter D = 8,
   parameter AW = 3
) (
   input wire sys_clk, // system clock
   input wire rst_b, // sync reset, active low
   input wire [W-1:0] wr_data, // byte in
   input wire wr_valid, // byte in valid
   output wire wr_ready, // room available
   output reg [W-1:0] rd_data, // byte out
   output wire rd_valid, // byte out valid
   input wire rd_ready // consumer takes byte
);
   reg [W-1:0] mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire do_wr;
   wire do_rd;
   assign wr_ready = (cnt_q != D);
   assign rd_valid = (cnt_q != 0);
   assign do_wr = wr_valid & wr_ready;
   assign do_rd = rd_valid & rd_ready;
   always @* begin
      rd_data = mem_q[rp_q];
   end
   // pointer and storage update
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            mem_q[wp_q] <= wr_data;
            wp_q <= wp_q + 1'b1;
         end
         if (do_rd)
            rp_q <= rp_q + 1'b1;
         if (do_wr & ~do_rd)
            cnt_q <= cnt_q + 1'b1;
         else if (do_rd & ~do_wr)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // pwr_cmd_fifo

// ===== src/pwr_cmd_sender.v
// power switch command framer with per-host strings and uart transmitter
`timescale 1ns/1ns
`include "pwr_cmd_map.vh"
module pwr_cmd_sender (
   input wire sys_clk, // 100 MHz clock
   input wire rst_b, // sync reset, active low
   input wire cfg_we, // write one outlet entry of a host
   input wire [2:0] cfg_host, // host index being configured
   input wire [1:0] cfg_slot, // outlet slot 0..3 within host group
   input wire cfg_en, // slot in use
   input wire [3:0] cfg_box, // box number 0..9
   input wire [3:0] cfg_port, // port number 0..9
   input wire [15:0] baud_div, // clocks per bit, matches the box speed
   input wire req_valid, // switch request
   input wire [2:0] req_host, // host to switch
   input wire req_on, // 1 on, 0 off
   output wire req_ready, // framer idle
   output reg busy_q, // sequence in progress
   output reg tx_q // serial line out, idle high
);
   // ********************************************************************
   // per host outlet table
   // ********************************************************************
   reg en_q [0:31];
   reg [3:0] box_q [0:31];
   reg [3:0] port_q [0:31];
   integer i;
   // digit to ascii, used for box and port
   function [7:0] dig;
      input [3:0] v;
      begin
         // clamp so a bad entry never leaves the digit range
         dig = `CH_ZERO + {4'h0, (v > `MAX_DIGIT) ? `MAX_DIGIT : v};
      end
   endfunction
   // table write; on and off strings share address, state picks char
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         for (i = 0; i < `TBL_SIZE; i = i + 1)
            en_q[i] <= 1'b0;
      end else if (cfg_we) begin
         en_q[{cfg_host, cfg_slot}] <= cfg_en;
         box_q[{cfg_host, cfg_slot}] <= cfg_box;
         port_q[{cfg_host, cfg_slot}] <= cfg_port;
      end
   end
   // ********************************************************************
   // framer
   // ********************************************************************
   localparam S_IDLE = 2'b00;
   localparam S_SLOT = 2'b01;
   localparam S_EMIT = 2'b10;
   reg [1:0] st_q;
   reg [2:0] host_q;
   reg on_q;
   reg [2:0] slot_q; // walks 0..4
   reg [2:0] ch_q; // char index in command
   reg sent_any_q;
   reg [7:0] byte_d;
   wire f_ready;
   wire [4:0] idx;
   wire push;
   assign idx = {host_q, slot_q[1:0]};
   assign req_ready = (st_q == S_IDLE);
   assign push = (st_q == S_EMIT) & f_ready;
   // byte selection; token goes before every command except the first
   always @* begin
      case (ch_q)
         `CI_BSL: byte_d = `CH_BSL;
         `CI_STAR: byte_d = `CH_STAR;
         `CI_P: byte_d = `CH_P;
         `CI_BOX: byte_d = dig(box_q[idx]);
         `CI_PORT: byte_d = dig(port_q[idx]);
         `CI_EQ: byte_d = `CH_EQ;
         `CI_ST: byte_d = on_q ? `CH_ONE : `CH_ZERO;
         default: byte_d = `CH_CR;
      endcase
   end
   // sequence walk over up to four outlets of the host
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         host_q <= 3'h0;
         on_q <= 1'b0;
         slot_q <= 3'h0;
         ch_q <= `CI_BSL;
         sent_any_q <= 1'b0;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (req_valid) begin
                  host_q <= req_host;
                  on_q <= req_on;
                  slot_q <= 3'h0;
                  sent_any_q <= 1'b0;
                  st_q <= S_SLOT;
               end
            end
            S_SLOT: begin
               if (slot_q == `MAX_OUT)
                  st_q <= S_IDLE;
               else if (en_q[idx]) begin
                  ch_q <= sent_any_q ? `CI_BSL : `CI_P;
                  st_q <= S_EMIT;
               end else
                  slot_q <= slot_q + 3'h1;
            end
            S_EMIT: begin
               if (f_ready) begin
                  if (ch_q == `CI_CR) begin
                     sent_any_q <= 1'b1;
                     slot_q <= slot_q + 3'h1;
                     st_q <= S_SLOT;
                  end else
                     ch_q <= ch_q + 3'h1;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
   // ********************************************************************
   // fifo and uart transmitter
   // ********************************************************************
   wire [7:0] f_data;
   wire f_valid;
   wire f_take;
   reg [9:0] sh_q;
   reg [3:0] bits_q;
   reg [15:0] bcnt_q;
   assign f_take = (bits_q == 4'h0) & f_valid;
   pwr_cmd_fifo #(.W(8), .D(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .wr_data(byte_d),
      .wr_valid(push),
      .wr_ready(f_ready),
      .rd_data(f_data),
      .rd_valid(f_valid),
      .rd_ready(f_take)
   );
   // 8n1 shift out at the configured line speed
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         sh_q <= `LINE_IDLE;
         bits_q <= 4'h0;
         bcnt_q <= 16'h0000;
         tx_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         busy_q <= (st_q != S_IDLE) | f_valid | (bits_q != 4'h0);
         if (f_take) begin
            sh_q <= {1'b1, f_data, 1'b0};
            bits_q <= `FRAME_BITS;
            bcnt_q <= 16'h0000;
         end else if (bits_q != 4'h0) begin
            tx_q <= sh_q[0];
            if (bcnt_q >= baud_div - 16'h0001) begin
               bcnt_q <= 16'h0000;
               sh_q <= {1'b1, sh_q[9:1]};
               bits_q <= bits_q - 4'h1;
            end else
               bcnt_q <= bcnt_q + 16'h0001;
         end else
            tx_q <= 1'b1;
      end
   end
endmodule // pwr_cmd_sender

// ===== verification/pwr_cmd_properties.sv
// port checks for the power command sender
`timescale 1ns/1ns
module pwr_cmd_chk(
   input wire sys_clk, // clock
   input wire rst_b, // reset
   input wire cfg_we, // table write
   input wire req_valid, // request
   input wire [15:0] baud_div, // bit time
   input wire req_ready, // idle
   input wire busy_q, // busy
   input wire tx_q // line
);
   reg last_q;
   reg [19:0] run_q;
   // length of the current line level, bits must be whole periods
   always @(posedge sys_clk) begin
      last_q <= tx_q;
      run_q <= (tx_q != last_q) ? 20'h0_0001 : run_q + 20'h0_0001;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_rst;
      disable iff (1'b0) !rst_b |=> tx_q && !busy_q && req_ready;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   property p_idle; !busy_q |-> tx_q; endproperty
   a_idle: assert property (p_idle) else $error("line low idle");
   property p_start; $fell(tx_q) |-> busy_q; endproperty
   a_start: assert property (p_start) else $error("stray start");
   property p_bit; $rose(tx_q) |-> run_q % baud_div == 0; endproperty
   a_bit: assert property (p_bit) else $error("bit length");
   property p_low; $rose(tx_q) |-> run_q <= 9 * baud_div; endproperty
   a_low: assert property (p_low) else $error("no stop bit");
   property p_end; $fell(busy_q) |-> tx_q && last_q; endproperty
   a_end: assert property (p_end) else $error("cut frame");
   property p_cfg;
      cfg_we && !req_valid && req_ready && !busy_q |=> !busy_q;
   endproperty
   a_cfg: assert property (p_cfg) else $error("cfg sent");
   property p_take; req_valid && req_ready |=> !req_ready; endproperty
   a_take: assert property (p_take) else $error("no take");
endmodule // pwr_cmd_chk
bind pwr_cmd_sender pwr_cmd_chk chk_i(.sys_clk, .rst_b, .cfg_we,
   .req_valid, .baud_div, .req_ready, .busy_q, .tx_q);

// ===== verification/pwr_box_model.sv
// serial power switch box model collecting received bytes
`timescale 1ns/1ns
module pwr_box_model(
   input wire sys_clk, // clock
   input wire rx, // line from sender
   input wire [15:0] baud_div // bit time
);
   logic [7:0] got_q[$];
   // 8N1 receiver, mid-bit sampling at the shared speed
   initial begin : rx_loop
      logic [7:0] b;
      forever begin
         @(negedge rx);
         repeat (baud_div / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (baud_div) @(posedge sys_clk);
            b[i] = rx;
         end
         repeat (baud_div) @(posedge sys_clk);
         if (rx) got_q.push_back(b); // bad stop drops byte
      end
   end
endmodule // pwr_box_model

// ===== verification/tb_top.sv
// testbench for the power switch command sender
`timescale 1ns/1ns
`include "pwr_cmd_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
   error_cnt++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
   logic sys_clk, rst_b, cfg_we, cfg_en, req_valid, req_on;
   logic [2:0] cfg_host, req_host;
   logic [1:0] cfg_slot;
   logic [3:0] cfg_box, cfg_port;
   logic [15:0] baud_div;
   wire req_ready, busy_q, tx_q;
   int error_cnt, total_checks;
   logic [7:0] exp_q[$];
   pwr_cmd_sender pwr_cmd_sender_i(.sys_clk(sys_clk), .rst_b(rst_b),
      .cfg_we(cfg_we), .cfg_host(cfg_host), .cfg_slot(cfg_slot),
      .cfg_en(cfg_en), .cfg_box(cfg_box), .cfg_port(cfg_port),
      .baud_div(baud_div), .req_valid(req_valid), .req_host(req_host),
      .req_on(req_on), .req_ready(req_ready), .busy_q(busy_q), .tx_q(tx_q));
   pwr_box_model pwr_box_model_i(.sys_clk(sys_clk), .rx(tx_q),
      .baud_div(baud_div));
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task cfg(input [2:0] h, input [1:0] s, input e, input [3:0] b, p);
      @(posedge sys_clk) #1;
      {cfg_we, cfg_host, cfg_slot, cfg_en, cfg_box, cfg_port} =
         {1'b1, h, s, e, b, p};
      @(posedge sys_clk) #1 cfg_we = 0;
   endtask
   // digits above nine clamp to nine
   function [7:0] dg(input [3:0] v);
      dg = `CH_ZERO + ((v > 4'h9) ? 4'h9 : v);
   endfunction
   task add(input [3:0] b, p, input on, first);
      if (!first) exp_q = {exp_q, `CH_BSL, `CH_STAR};
      exp_q = {exp_q, `CH_P, dg(b), dg(p), `CH_EQ,
         on ? `CH_ONE : `CH_ZERO, `CH_CR};
   endtask
   task req(input [2:0] h, input on);
      {req_valid, req_host, req_on} = {1'b1, h, on};
      while (!req_ready) @(posedge sys_clk) #1;
      @(posedge sys_clk) #1;
   endtask
   // wait out the sequence, then compare the received bytes
   task check_seq(input string n);
      int k;
      req_valid = 0;
      for (k = 0; k < 8 && busy_q !== 1'b1; k++) @(posedge sys_clk) #1;
      for (k = 0; k < 9000 && busy_q !== 1'b0; k++) @(posedge sys_clk) #1;
      `CHK(n, exp_q.size(), pwr_box_model_i.got_q.size())
      foreach (exp_q[i]) `CHK(n, exp_q[i], pwr_box_model_i.got_q[i])
      exp_q = {};
      pwr_box_model_i.got_q = {};
   endtask
   // on then off queued back to back
   task t_single;
      cfg(3'h1, 2'h0, 1'b1, 4'h2, 4'h5);
      add(4'h2, 4'h5, 1'b1, 1'b1);
      add(4'h2, 4'h5, 1'b0, 1'b1);
      req(3'h1, 1'b1);
      req(3'h1, 1'b0);
      check_seq("single");
   endtask
   // full group of four, then a hole in the group, then no outlets
   task t_chain;
      cfg(3'h6, 2'h0, 1'b1, 4'h0, 4'h9);
      cfg(3'h6, 2'h1, 1'b1, 4'h9, 4'h0);
      cfg(3'h6, 2'h2, 1'b1, 4'h3, 4'h7);
      cfg(3'h6, 2'h3, 1'b1, 4'hc, 4'h1);
      add(4'h0, 4'h9, 1'b0, 1'b1);
      add(4'h9, 4'h0, 1'b0, 1'b0);
      add(4'h3, 4'h7, 1'b0, 1'b0);
      add(4'hc, 4'h1, 1'b0, 1'b0);
      req(3'h6, 1'b0);
      check_seq("chain");
      cfg(3'h6, 2'h1, 1'b0, 4'h9, 4'h0);
      add(4'h0, 4'h9, 1'b1, 1'b1);
      add(4'h3, 4'h7, 1'b1, 1'b0);
      add(4'hc, 4'h1, 1'b1, 1'b0);
      req(3'h6, 1'b1);
      check_seq("gap");
      req(3'h5, 1'b1);
      check_seq("none");
   endtask
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   // watchdog far beyond the longest run
   initial begin
      #400000;
      error_cnt++;
      give_verdict;
   end
   initial begin
      {rst_b, cfg_we, cfg_en, req_valid, req_on} = 0;
      {cfg_host, req_host, cfg_slot, cfg_box, cfg_port} = 0;
      baud_div = 16'h0004;
      repeat (12) @(posedge sys_clk);
      #1 rst_b = 1;
      t_single;
      t_chain;
      give_verdict;
   end
endmodule // tb_top
